/* File: core/ncu_core.sv */
`timescale 1ns/10ps
`include "ncu_defs.svh"
module ncu_core import ncu_pkg::*; (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Pins from outside the clock domain.
  input wire logic sclk,
  input wire logic boot_sel,
  // Register access decoded from the serial control port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Status pin and active configuration.
  output logic status_pin_first_q,
  output logic [`NCU_BANK_N*8-1:0] active_cfg_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  ncu_state_e state_q;
  ncu_dir_e dir_q;
  logic [4:0] tptr_q;
  logic [6:0] cnt_q;
  logic [15:0] addr_q;
  logic [`NCU_NV_AW-1:0] nvptr_q;
  logic pend_q;
  logic err_q;
  logic apply_q;
  logic unlock_q;
  logic soft_q;
  logic store_q;
  logic stpin_en_q;
  ncu_byte_t buf_q [`NCU_BANK_N];
  ncu_byte_t tbl_q [`NCU_TBL_N];
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;

  ncu_nv_if nv ();

  ncu_sync u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in({boot_sel, sclk}),
    .level(pin_lvl),
    .rise(pin_rise)
  );

  ncu_nv_mem u_nv (
    .core_clk(core_clk),
    .rstn(rstn),
    .nv(nv.mem)
  );

  wire sclk_rise = pin_rise[0];
  wire boot_low = !pin_lvl[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Register decode.

  wire wr_apply = reg_wr && reg_addr == `NCU_A_APPLY;
  wire wr_stpin = reg_wr && reg_addr == `NCU_A_STPIN;
  wire wr_ctl1 = reg_wr && reg_addr == `NCU_A_CTL1;
  wire wr_ctl2 = reg_wr && reg_addr == `NCU_A_CTL2;
  wire tbl_hit = reg_addr >= `NCU_A_TBL0 && reg_addr <= `NCU_A_TBL_LAST;
  wire [4:0] tbl_idx = 5'(reg_addr - `NCU_A_TBL0);
  wire bank_hit = reg_addr >= `NCU_A_BANK0 && reg_addr < (`NCU_A_BANK0 + 12'(`NCU_BANK_N));
  wire [3:0] bank_idx = 4'(reg_addr - `NCU_A_BANK0);
  wire set_apply = wr_apply && reg_wdata[`NCU_B_APPLY];
  wire set_store = wr_ctl2 && reg_wdata[`NCU_B_STORE];
  // A reload request while boot select is high is dropped at once.
  wire set_soft = wr_ctl1 && reg_wdata[`NCU_B_SOFT] && boot_low;

  wire [7:0] rd_mux =
    bank_hit ? buf_q[bank_idx] :
    tbl_hit ? tbl_q[tbl_idx] :
    reg_addr == `NCU_A_APPLY ? 8'(apply_q) << `NCU_B_APPLY :
    reg_addr == `NCU_A_STPIN ? 8'(stpin_en_q) << `NCU_B_STPIN :
    reg_addr == `NCU_A_PEND ? 8'(pend_q) << `NCU_B_PEND :
    reg_addr == `NCU_A_ERR ? 8'(err_q) << `NCU_B_ERR :
    reg_addr == `NCU_A_CTL1 ? (8'(soft_q) << `NCU_B_SOFT) | (8'(unlock_q) << `NCU_B_UNLOCK) :
    reg_addr == `NCU_A_CTL2 ? 8'(store_q) << `NCU_B_STORE :
    8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Segment walk decode.

  wire tbl_end = tptr_q >= 5'(`NCU_TBL_N);
  wire [7:0] tbl_cur = tbl_end ? `NCU_OP_END : tbl_q[tptr_q];
  wire is_op = tbl_cur[`NCU_B_OPFLAG];
  wire idle = state_q == NCU_IDLE;
  wire start_store = idle && store_q && unlock_q;
  wire drop_store = idle && store_q && !unlock_q;
  wire start_load = idle && soft_q && !store_q;
  wire op_apply = state_q == NCU_OP && tbl_cur == `NCU_OP_APPLY && dir_q == NCU_DIR_LOAD;
  wire loc_ok = addr_q >= 16'(`NCU_A_BANK0) && addr_q < (16'(`NCU_A_BANK0) + 16'(`NCU_BANK_N));
  wire [3:0] loc_idx = 4'(addr_q - 16'(`NCU_A_BANK0));
  wire step = (state_q == NCU_XFER && dir_q == NCU_DIR_STORE) || (state_q == NCU_RWAIT && nv.rvalid);
  wire load_wr = state_q == NCU_RWAIT && nv.rvalid && loc_ok;
  wire do_apply = (apply_q && sclk_rise) || op_apply;

  assign nv.req = state_q == NCU_XFER;
  // A store locked during its walk keeps walking but writes no byte after the lock.
  assign nv.we = state_q == NCU_XFER && dir_q == NCU_DIR_STORE && unlock_q;
  assign nv.addr = nvptr_q;
  assign nv.wdata = loc_ok ? buf_q[loc_idx] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      apply_q <= 1'b0;
      unlock_q <= 1'b0;
      soft_q <= 1'b0;
      store_q <= 1'b0;
      stpin_en_q <= 1'b0;
    end else begin
      // A new write in the same cycle as the edge waits for the next edge.
      if (set_apply) begin
        apply_q <= 1'b1;
      end else if (sclk_rise) begin
        apply_q <= 1'b0;
      end
      if (wr_ctl1) begin
        unlock_q <= reg_wdata[`NCU_B_UNLOCK];
      end
      if (set_soft) begin
        soft_q <= 1'b1;
      end else if (start_load) begin
        soft_q <= 1'b0;
      end
      if (set_store) begin
        store_q <= 1'b1;
      end else if (drop_store || (state_q == NCU_DONE && dir_q == NCU_DIR_STORE)) begin
        store_q <= 1'b0;
      end
      if (wr_stpin) begin
        stpin_en_q <= reg_wdata[`NCU_B_STPIN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Segment walk.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= NCU_IDLE;
      dir_q <= NCU_DIR_STORE;
      tptr_q <= 5'h00;
      cnt_q <= 7'h00;
      addr_q <= 16'h0000;
      nvptr_q <= '0;
      pend_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      unique case (state_q)
        NCU_IDLE: begin
          if (start_store || start_load) begin
            dir_q <= start_store ? NCU_DIR_STORE : NCU_DIR_LOAD;
            tptr_q <= 5'h00;
            nvptr_q <= '0;
            pend_q <= 1'b1;
            err_q <= 1'b0;
            state_q <= NCU_OP;
          end
        end
        NCU_OP: begin
          if (tbl_cur == `NCU_OP_END) begin
            state_q <= NCU_DONE;
          end else if (is_op) begin
            tptr_q <= tptr_q + 5'h01;
          end else begin
            cnt_q <= tbl_cur[6:0];
            tptr_q <= tptr_q + 5'h01;
            state_q <= NCU_AHI;
          end
        end
        NCU_AHI: begin
          addr_q[15:8] <= tbl_cur;
          tptr_q <= tptr_q + 5'h01;
          state_q <= NCU_ALO;
        end
        NCU_ALO: begin
          addr_q[7:0] <= tbl_cur;
          tptr_q <= tptr_q + 5'h01;
          state_q <= NCU_XFER;
        end
        NCU_XFER: begin
          if (dir_q == NCU_DIR_LOAD) begin
            state_q <= NCU_RWAIT;
          end
        end
        NCU_RWAIT: begin
          if (nv.rvalid && nv.rerr) begin
            err_q <= 1'b1;
          end
        end
        NCU_DONE: begin
          pend_q <= 1'b0;
          state_q <= NCU_IDLE;
        end
      endcase
      if (step) begin
        addr_q <= addr_q + 16'h0001;
        nvptr_q <= nvptr_q + 1'b1;
        cnt_q <= cnt_q - 7'h01;
        if (&nvptr_q && cnt_q != 7'h00) begin
          // Table asks for more bytes than the memory holds.
          err_q <= 1'b1;
          state_q <= NCU_DONE;
        end else begin
          state_q <= cnt_q == 7'h00 ? NCU_OP : NCU_XFER;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Table, staged bank and active bank.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NCU_TBL_N; i++) begin
        tbl_q[i] <= i == 0 ? `NCU_TBL_RST0 : i == 1 ? `NCU_TBL_RST1 : i == 2 ? `NCU_TBL_RST2 :
                    i == 3 ? `NCU_TBL_RST3 : `NCU_TBL_RSTX;
      end
    end else if (reg_wr && tbl_hit) begin
      tbl_q[tbl_idx] <= reg_wdata;
    end
  end

  // Reload data wins over a host write landing in the same cycle.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NCU_BANK_N; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (load_wr) begin
      buf_q[loc_idx] <= nv.rdata;
    end else if (reg_wr && bank_hit) begin
      buf_q[bank_idx] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_cfg_q <= '0;
    end else if (do_apply) begin
      for (int i = 0; i < `NCU_BANK_N; i++) begin
        active_cfg_q[i*8 +: 8] <= buf_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port and status pin.

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
      status_pin_first_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
      status_pin_first_q <= stpin_en_q && pend_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [`NCU_BANK_N*8-1:0] buf_flat;
  always_comb begin
    buf_flat = '0;
    for (int i = 0; i < `NCU_BANK_N; i++) begin
      buf_flat[i*8 +: 8] = buf_q[i];
    end
  end

  default clocking cb_chk @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  property p_apply_copy;
    (apply_q && sclk_rise) |=> active_cfg_q == $past(buf_flat);
  endproperty
  a_apply_copy: assert property (p_apply_copy) else $error("active bank not copied on edge");
  property p_apply_wait;
    (apply_q && !sclk_rise && !op_apply) |=> $stable(active_cfg_q);
  endproperty
  a_apply_wait: assert property (p_apply_wait) else $error("active bank changed before edge");
  property p_apply_clear;
    (apply_q && sclk_rise && !set_apply) |=> !apply_q;
  endproperty
  a_apply_clear: assert property (p_apply_clear) else $error("apply bit did not clear");
  property p_table_walk;
    state_q == NCU_AHI |=> state_q == NCU_ALO ##1 state_q == NCU_XFER;
  endproperty
  a_table_walk: assert property (p_table_walk) else $error("entry header walk broken");
  property p_op_end;
    (state_q == NCU_OP && tbl_cur == `NCU_OP_END) |=> state_q == NCU_DONE ##1 !pend_q;
  endproperty
  a_op_end: assert property (p_op_end) else $error("end opcode did not finish walk");
  property p_store_start;
    start_store |=> pend_q && state_q == NCU_OP && dir_q == NCU_DIR_STORE;
  endproperty
  a_store_start: assert property (p_store_start) else $error("store did not start");
  property p_pin;
    (pend_q && stpin_en_q) |=> status_pin_first_q;
  endproperty
  a_pin: assert property (p_pin) else $error("status pin missed pending");
  // Parity faults cannot be provoked from the bus, so the overrun path keeps this check alive.
  property p_err;
    ((nv.rvalid && nv.rerr && state_q == NCU_RWAIT) || (step && &nvptr_q && cnt_q != 7'h00)) |=> err_q ##1 err_q;
  endproperty
  a_err: assert property (p_err) else $error("data error not flagged");
  property p_soft;
    (set_soft && idle && !store_q && !soft_q) |=> soft_q ##1 (!soft_q && pend_q && dir_q == NCU_DIR_LOAD);
  endproperty
  a_soft: assert property (p_soft) else $error("reload not started or bit stuck");
  property p_lock;
    !unlock_q |-> !nv.we;
  endproperty
  a_lock: assert property (p_lock) else $error("memory written while locked");
  property p_store_done;
    (state_q == NCU_DONE && dir_q == NCU_DIR_STORE && !set_store) |=> !store_q && !pend_q;
  endproperty
  a_store_done: assert property (p_store_done) else $error("store bit not cleared");
  property p_locked_store;
    drop_store |=> !store_q && !pend_q && state_q == NCU_IDLE;
  endproperty
  a_locked_store: assert property (p_locked_store) else $error("locked store did not drop");

  c_store: cover property (state_q == NCU_DONE && dir_q == NCU_DIR_STORE);
  c_load: cover property (op_apply);
  c_edge: cover property (apply_q && sclk_rise);

endmodule

/* File: core/ncu_defs.svh */
`ifndef NCU_DEFS_SVH
`define NCU_DEFS_SVH

// Register offsets on the serial control port.
`define NCU_A_STPIN 12'h232
`define NCU_A_APPLY 12'h234
`define NCU_A_TBL0 12'hA00
`define NCU_A_TBL_LAST 12'hA16
`define NCU_A_PEND 12'hB00
`define NCU_A_ERR 12'hB01
`define NCU_A_CTL1 12'hB02
`define NCU_A_CTL2 12'hB03
`define NCU_A_BANK0 12'h010

// Sizes.
`define NCU_BANK_N 16
`define NCU_TBL_N 23
`define NCU_NV_DEPTH 256
`define NCU_NV_AW 8

// Field positions.
`define NCU_B_STPIN 4
`define NCU_B_APPLY 0
`define NCU_B_PEND 0
`define NCU_B_ERR 0
`define NCU_B_SOFT 1
`define NCU_B_UNLOCK 0
`define NCU_B_STORE 0
`define NCU_B_OPFLAG 7

// Segment table opcodes and reset image.
`define NCU_OP_APPLY 8'h80
`define NCU_OP_END 8'hFF
`define NCU_TBL_RST0 8'h0F
`define NCU_TBL_RST1 8'h00
`define NCU_TBL_RST2 8'h10
`define NCU_TBL_RST3 `NCU_OP_APPLY
`define NCU_TBL_RSTX `NCU_OP_END

`endif

/* File: core/ncu_nv_if.sv */
`timescale 1ns/10ps
`include "ncu_defs.svh"
interface ncu_nv_if;
  logic req;
  logic we;
  logic [`NCU_NV_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic rerr;
  modport ctrl (output req, we, addr, wdata, input rdata, rvalid, rerr);
  modport mem (input req, we, addr, wdata, output rdata, rvalid, rerr);
endinterface

/* File: core/ncu_nv_mem.sv */
`timescale 1ns/10ps
`include "ncu_defs.svh"
module ncu_nv_mem (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Controller side.
  ncu_nv_if.mem nv
);

  // Bit 8 keeps even parity so a corrupted byte shows on readback.
  logic [8:0] mem_q [`NCU_NV_DEPTH];
  logic [8:0] rd_q;
  logic rv_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `NCU_NV_DEPTH; i++) begin
        mem_q[i] <= 9'h000;
      end
    end else if (nv.req && nv.we) begin
      mem_q[nv.addr] <= {^nv.wdata, nv.wdata};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_q <= 9'h000;
      rv_q <= 1'b0;
    end else begin
      rv_q <= nv.req && !nv.we;
      if (nv.req && !nv.we) begin
        rd_q <= mem_q[nv.addr];
      end
    end
  end

  assign nv.rdata = rd_q[7:0];
  assign nv.rvalid = rv_q;
  assign nv.rerr = rv_q && ((^rd_q[7:0]) != rd_q[8]);

endmodule

/* File: core/ncu_pkg.sv */
package ncu_pkg;

  typedef enum logic [2:0] {
    NCU_IDLE,
    NCU_OP,
    NCU_AHI,
    NCU_ALO,
    NCU_XFER,
    NCU_RWAIT,
    NCU_DONE
  } ncu_state_e;

  typedef enum logic {
    NCU_DIR_STORE,
    NCU_DIR_LOAD
  } ncu_dir_e;

  typedef logic [7:0] ncu_byte_t;

endpackage

/* File: core/ncu_sync.sv */
`timescale 1ns/10ps
module ncu_sync (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Pins and their synchronised forms.
  input wire logic [1:0] async_in,
  output logic [1:0] level,
  output logic [1:0] rise
);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      logic meta_q;
      logic sync_q;
      logic prev_q;
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          meta_q <= async_in[g];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      assign level[g] = sync_q;
      assign rise[g] = sync_q & ~prev_q;
    end
  endgenerate

endmodule

/* File: tb/ncu_core_tb_top.sv */
`timescale 1ns/10ps
module ncu_core_tb_top import ncu_pkg::*;;
  logic core_clk, rstn, boot_sel, reg_wr, reg_rd, reg_rvalid_q, status_pin_first_q, sclk_run;
  logic sclk = 1'b0;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q;
  logic [127:0] active_cfg_q;
  logic [1:0] sclk_cnt = 2'h0;
  logic [31:0] seed;
  int mismatches, samples_checked;
  int stg[16], act[16], nv[16];
  logic [11:0] n_list[7] = '{12'h234, 12'h232, 12'hB00, 12'hB01, 12'hB02, 12'hB03, 12'h300};
  logic [7:0] tbl_a[4] = '{8'h01, 8'h00, 8'h14, 8'hFF};
  // The third segment starts on the last memory byte, so it overruns the memory.
  logic [7:0] tbl_b[10] = '{8'h7F, 8'h00, 8'h10, 8'h7E, 8'h00, 8'h10, 8'h7F, 8'h00, 8'h10, 8'hFF};

  ncu_core ncu_core_inst (.core_clk(core_clk), .rstn(rstn), .sclk(sclk), .boot_sel(boot_sel),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .status_pin_first_q(status_pin_first_q), .active_cfg_q(active_cfg_q));
  ncu_host_model ncu_host_model_inst (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The serial clock runs at 200 ns only while asked and always parks low.
  always @(posedge core_clk) begin
    if (sclk_run || sclk) begin
      sclk_cnt <= sclk_cnt + 2'h1;
      sclk <= (sclk_cnt == 2'h3) ? ~sclk : sclk;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [127:0] pack();
    logic [127:0] v;
    for (int i = 0; i < 16; i++) begin
      v[8*i +: 8] = act[i][7:0];
    end
    return v;
  endfunction

  task automatic report_and_stop();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("mismatch at %0t: %s", $time, what);
    report_and_stop();
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bank(input string what);
    samples_checked++;
    if (active_cfg_q !== pack()) begin
      mismatches++;
      $display("mismatch at %0t: %s active bank %h expected %h", $time, what, active_cfg_q, pack());
    end
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    ncu_host_model_inst.rd(a, d, ok);
    if (!ok) begin
      give_up("no read answer");
    end
    chk8(d, e, "register readback");
  endtask

  task automatic fill_bank(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      stg[i] = xs() & 255;
      ncu_host_model_inst.wr(12'(16 + i), stg[i][7:0]);
    end
  endtask

  task automatic staged_chk();
    for (int i = 0; i < 16; i++) begin
      rd_chk(12'(16 + i), stg[i][7:0]);
    end
  endtask

  // Starts a transfer and polls it out, then compares busy and error against the expected values.
  task automatic xfer(input logic [11:0] a, input logic [7:0] d, input bit exp_busy, input logic [7:0] e);
    bit busy, ok;
    logic [7:0] err;
    ncu_host_model_inst.wr(a, d);
    ncu_host_model_inst.wait_idle(busy, err, ok);
    if (!ok) begin
      give_up("transfer never finished");
    end
    chk8({7'h0, busy}, {7'h0, exp_busy}, "pending seen");
    chk8(err & 8'h01, e, "error bit");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    mismatches = 0;
    samples_checked = 0;
    seed = 32'h0001_41C2;
    rstn = 1'b0;
    sclk_run = 1'b0;
    boot_sel = 1'b0;
    foreach (act[i]) begin
      act[i] = 0;
      nv[i] = 0;
    end
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 23; i++) begin
      rd_chk(12'hA00 + 12'(i), (i < 5) ? 8'(40'h0F_0010_80FF >> (32 - 8 * i)) : 8'hFF);
    end
    foreach (n_list[k]) begin
      rd_chk(n_list[k], 8'h00);
    end
    chk_bank("after reset");
    // Apply waits for a serial clock edge, then copies and clears itself.
    fill_bank(0, 15);
    ncu_host_model_inst.wr(12'h234, 8'h01);
    repeat (20) @(posedge core_clk);
    chk_bank("before serial edge");
    act = stg;
    sclk_run <= 1'b1;
    for (n = 0; n < 60 && active_cfg_q !== pack(); n++) begin
      @(posedge core_clk);
    end
    sclk_run <= 1'b0;
    chk_bank("after serial edge");
    rd_chk(12'h234, 8'h00);
    xfer(12'hB03, 8'h01, 1'b0, 8'h00);
    rd_chk(12'hB03, 8'h00);
    // Nothing was stored, so a reload brings back zeros and applies them.
    xfer(12'hB02, 8'h02, 1'b1, 8'h00);
    foreach (stg[i]) begin
      stg[i] = 0;
    end
    act = stg;
    chk_bank("after locked store and reload");
    staged_chk();
    rd_chk(12'hB02, 8'h00);
    fill_bank(0, 15);
    ncu_host_model_inst.wr(12'h232, 8'h10);
    ncu_host_model_inst.wr(12'hB02, 8'h01);
    ncu_host_model_inst.wr(12'hB03, 8'h01);
    for (n = 0; n < 10 && status_pin_first_q !== 1'b1; n++) begin
      @(posedge core_clk);
    end
    chk8({7'h0, status_pin_first_q}, 8'h01, "status pin during store");
    xfer(12'h300, 8'h00, 1'b1, 8'h00);
    chk8({7'h0, status_pin_first_q}, 8'h00, "status pin after store");
    rd_chk(12'hB03, 8'h00);
    rd_chk(12'hB02, 8'h01);
    nv = stg;
    fill_bank(0, 15);
    xfer(12'hB02, 8'h03, 1'b1, 8'h00);
    stg = nv;
    act = stg;
    chk_bank("after reload");
    staged_chk();
    rd_chk(12'hB02, 8'h01);
    // Boot select high drops the reload request.
    boot_sel <= 1'b1;
    fill_bank(0, 0);
    xfer(12'hB02, 8'h03, 1'b0, 8'h00);
    rd_chk(12'h010, stg[0][7:0]);
    boot_sel <= 1'b0;
    // One short segment and no apply opcode.
    foreach (tbl_a[k]) begin
      ncu_host_model_inst.wr(12'hA00 + 12'(k), tbl_a[k]);
    end
    xfer(12'hB03, 8'h01, 1'b1, 8'h00);
    nv[0] = stg[4];
    nv[1] = stg[5];
    fill_bank(4, 6);
    xfer(12'hB02, 8'h03, 1'b1, 8'h00);
    stg[4] = nv[0];
    stg[5] = nv[1];
    staged_chk();
    chk_bank("no apply opcode in table");
    // Three segments ask for more than the memory holds.
    foreach (tbl_b[k]) begin
      ncu_host_model_inst.wr(12'hA00 + 12'(k), tbl_b[k]);
    end
    xfer(12'hB03, 8'h01, 1'b1, 8'h01);
    report_and_stop();
  end
endmodule

/* File: tb/ncu_host_model.sv */
`timescale 1ns/10ps
module ncu_host_model (
  // Clock.
  input wire logic core_clk,
  // Register strobes towards the device.
  output logic reg_wr,
  output logic reg_rd,
  output logic [11:0] reg_addr,
  output logic [7:0] reg_wdata,
  // Read answer from the device.
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d, output bit ok);
    int n;
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    n = 0;
    #1;
    while (reg_rvalid_q !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    ok = (reg_rvalid_q === 1'b1);
    d = reg_rdata_q;
  endtask

  // A new request is only safe once pending reads 0; the error bit is read after that.
  task automatic wait_idle(output bit busy, output logic [7:0] err, output bit ok);
    logic [7:0] d;
    int n;
    busy = 1'b0;
    ok = 1'b0;
    err = 8'hFF;
    for (n = 0; n < 400; n++) begin
      rd(12'hB00, d, ok);
      if (!ok) begin
        return;
      end
      if (d[0] === 1'b0) begin
        break;
      end
      busy = 1'b1;
    end
    if (n == 400) begin
      ok = 1'b0;
      return;
    end
    rd(12'hB01, err, ok);
  endtask
endmodule
